//--- hw/pag_pkg.sv
/*
 * Constants, register map and oscillator mode encoding for the port A block.
 * Assumes a 32-bit Avalon-MM slave window of eight aligned words.
 */
package pag_pkg;
   localparam int PAG_NPINS = 8;
   localparam int PAG_AW = 5;
   localparam int PAG_DW = 8;

   // Byte offsets of the register words
   localparam logic [4:0] PAG_DIR_OFS = 5'h00;
   localparam logic [4:0] PAG_PIN_OFS = 5'h04;
   localparam logic [4:0] PAG_LAT_OFS = 5'h08;
   localparam logic [4:0] PAG_ANA_OFS = 5'h0C;
   localparam logic [4:0] PAG_CMP_OFS = 5'h10;
   localparam logic [4:0] PAG_OSC_OFS = 5'h14;
   localparam logic [4:0] PAG_STA_OFS = 5'h18;

   // Reset values
   localparam logic [7:0] PAG_DIR_RST = 8'hFF;
   localparam logic [7:0] PAG_LAT_RST = 8'h00;
   localparam logic [7:0] PAG_ANA_RST = 8'h2F;
   localparam logic [7:0] PAG_CMP_RST = 8'h00;
   localparam logic [7:0] PAG_ANA_MASK = 8'h2F;

   // Comparator control field positions
   localparam int PAG_CMP_ON_BIT = 0;
   localparam int PAG_CMP_C1OE_BIT = 1;
   localparam int PAG_CMP_C2OE_BIT = 2;
   localparam int PAG_CMP_CREF_BIT = 3;
   localparam logic [7:0] PAG_CMP_MASK = 8'h0F;

   // Pins with special functions
   localparam int PAG_CREF_PIN = 2;
   localparam int PAG_CMP_PINS = 4;
   localparam int PAG_TMR_PIN = 4;
   localparam int PAG_SS_PIN = 5;
   localparam int PAG_OSC2_PIN = 6;
   localparam int PAG_OSC1_PIN = 7;

   // Cycle clock divider: Fosc/4
   localparam int PAG_CLK_DIV = 4;
   localparam int PAG_DIV_W = 2;

   typedef enum logic [2:0] {
      PAG_OSC_XTAL = 3'h0,
      PAG_OSC_RC_CLKOUT = 3'h1,
      PAG_OSC_RC_IO = 3'h2,
      PAG_OSC_INT_CLKOUT = 3'h3,
      PAG_OSC_INT_IO = 3'h4,
      PAG_OSC_EXT_CLKOUT = 3'h5,
      PAG_OSC_EXT_IO = 3'h6
   } pag_osc_e;

   localparam logic [2:0] PAG_OSC_RST = 3'h4;
endpackage : pag_pkg

//--- hw/pag_reg_if.sv
/*
 * Carrier between the bus slave and the register file of the port A block.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface pag_reg_if;
   logic wr_stb;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bus (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : pag_reg_if

//--- hw/pag_sync.sv
/*
 * Two-stage synchroniser for the pad inputs.
 * Assumes pad levels are asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module pag_sync
   import pag_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [PAG_NPINS-1:0] async_in,
   output logic [PAG_NPINS-1:0] sync_out
);
   logic [PAG_NPINS-1:0] meta_q;
   logic [PAG_NPINS-1:0] sync_q;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce) begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : pag_sync

//--- hw/pag_bus.sv
/*
 * Avalon-MM slave with one wait state per access.
 * Assumes the master holds its request until waitrequest is seen low.
 */
`timescale 1ns/1ps
module pag_bus
   import pag_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [PAG_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   pag_reg_if.bus rif
);
   logic wait_q;
   logic wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   wire req = avs_read | avs_write;

   // Low for exactly one cycle after a request is seen
   assign wait_d = ~(req & wait_q);
   assign rdata_d = (avs_read & wait_q) ? {24'h000000, rif.rdata} : rdata_q;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end else if (ce) begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // Write lands at the edge the master sees waitrequest low
   assign rif.wr_stb = avs_write & ~wait_q & avs_byteenable[0] & ce;
   assign rif.addr = avs_address;
   assign rif.wdata = avs_writedata[PAG_DW-1:0];
   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
endmodule : pag_bus

//--- hw/pag_top.sv
/*
 * Port A: eight-pin bidirectional GPIO with analog, comparator, reference
 * and oscillator pin sharing, registers on Avalon-MM.
 * Assumes clk_sys is the oscillator clock (Fosc), comparator results arrive
 * on clk_sys, and pad buffers are resolved outside from pin_out/pin_oe.
 */
`timescale 1ns/1ps
module pag_top
   import pag_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [PAG_AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [PAG_NPINS-1:0] pin_in,
   output logic [PAG_NPINS-1:0] pin_out,
   output logic [PAG_NPINS-1:0] pin_oe,
   input wire logic comparator_one_out,
   input wire logic comparator_two_out,
   output logic timer_clock_in,
   output logic slave_select_n,
   output logic comparator_ref_out
);
   pag_reg_if rif ();

   logic [PAG_NPINS-1:0] direction_q;
   logic [PAG_NPINS-1:0] direction_d;
   logic [PAG_NPINS-1:0] latch_q;
   logic [PAG_NPINS-1:0] latch_d;
   logic [PAG_NPINS-1:0] analog_q;
   logic [PAG_NPINS-1:0] analog_d;
   logic [PAG_NPINS-1:0] cmp_q;
   logic [PAG_NPINS-1:0] cmp_d;
   pag_osc_e osc_q;
   pag_osc_e osc_d;
   logic [PAG_DIV_W-1:0] div_q;
   logic [PAG_NPINS-1:0] pin_out_q;
   logic [PAG_NPINS-1:0] pin_oe_q;
   logic tmr_q;
   logic ss_n_q;
   logic cref_q;
   logic [PAG_NPINS-1:0] pin_sync;

   // Oscillator mode decoding
   function automatic logic osc2_is_io(input pag_osc_e m);
      return (m == PAG_OSC_RC_IO) || (m == PAG_OSC_INT_IO) || (m == PAG_OSC_EXT_IO);
   endfunction : osc2_is_io

   function automatic logic osc2_is_clkout(input pag_osc_e m);
      return (m == PAG_OSC_RC_CLKOUT) || (m == PAG_OSC_INT_CLKOUT)
         || (m == PAG_OSC_EXT_CLKOUT);
   endfunction : osc2_is_clkout

   function automatic logic osc1_is_io(input pag_osc_e m);
      return (m == PAG_OSC_INT_IO) || (m == PAG_OSC_INT_CLKOUT);
   endfunction : osc1_is_io

   function automatic pag_osc_e osc_decode(input logic [2:0] v);
      pag_osc_e m;
      m = PAG_OSC_XTAL;
      unique case (v)
         3'h0: m = PAG_OSC_XTAL;
         3'h1: m = PAG_OSC_RC_CLKOUT;
         3'h2: m = PAG_OSC_RC_IO;
         3'h3: m = PAG_OSC_INT_CLKOUT;
         3'h4: m = PAG_OSC_INT_IO;
         3'h5: m = PAG_OSC_EXT_CLKOUT;
         3'h6: m = PAG_OSC_EXT_IO;
         default: m = PAG_OSC_XTAL;
      endcase
      return m;
   endfunction : osc_decode

   pag_bus u_bus (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .rif(rif.bus)
   );

   pag_sync u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .ce(ce),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   // Address decode
   wire wr_dir = rif.wr_stb & (rif.addr == PAG_DIR_OFS);
   wire wr_pin = rif.wr_stb & (rif.addr == PAG_PIN_OFS);
   wire wr_lat = rif.wr_stb & (rif.addr == PAG_LAT_OFS);
   wire wr_ana = rif.wr_stb & (rif.addr == PAG_ANA_OFS);
   wire wr_cmp = rif.wr_stb & (rif.addr == PAG_CMP_OFS);
   wire wr_osc = rif.wr_stb & (rif.addr == PAG_OSC_OFS);

   // Control decode
   wire cmp_on = cmp_q[PAG_CMP_ON_BIT];
   wire c1_oe = cmp_q[PAG_CMP_C1OE_BIT];
   wire c2_oe = cmp_q[PAG_CMP_C2OE_BIT];
   wire cref_en = cmp_q[PAG_CMP_CREF_BIT];
   wire cycle_clk = div_q[PAG_DIV_W-1];

   // Oscillator ownership of the top two pins
   logic [PAG_NPINS-1:0] pin_free;
   logic [PAG_NPINS-1:0] din_en;
   logic [PAG_NPINS-1:0] dout_en;
   logic [PAG_NPINS-1:0] drv_val;
   logic [PAG_NPINS-1:0] drv_en;

   genvar gi;
   generate
      for (gi = 0; gi < PAG_NPINS; gi++) begin : g_pin
         if (gi == PAG_OSC2_PIN) begin : g_osc2
            assign pin_free[gi] = osc2_is_io(osc_q);
         end else if (gi == PAG_OSC1_PIN) begin : g_osc1
            assign pin_free[gi] = osc1_is_io(osc_q);
         end else begin : g_plain
            assign pin_free[gi] = 1'b1;
         end

         assign din_en[gi] = pin_free[gi] & ~analog_q[gi]
            & ~(cmp_on & (gi < PAG_CMP_PINS))
            & ~(cref_en & (gi == PAG_CREF_PIN));

         assign dout_en[gi] = pin_free[gi] & ~(cref_en & (gi == PAG_CREF_PIN));

         if (gi == PAG_TMR_PIN) begin : g_c1
            assign drv_val[gi] = c1_oe ? comparator_one_out : latch_q[gi];
         end else if (gi == PAG_SS_PIN) begin : g_c2
            assign drv_val[gi] = c2_oe ? comparator_two_out : latch_q[gi];
         end else if (gi == PAG_OSC2_PIN) begin : g_cycle_clock_out
            assign drv_val[gi] = osc2_is_clkout(osc_q) ? cycle_clk : latch_q[gi];
         end else begin : g_lat
            assign drv_val[gi] = latch_q[gi];
         end

         if (gi == PAG_OSC2_PIN) begin : g_oe6
            assign drv_en[gi] = (dout_en[gi] & ~direction_q[gi])
               | osc2_is_clkout(osc_q);
         end else begin : g_oen
            assign drv_en[gi] = dout_en[gi] & ~direction_q[gi];
         end
      end
   endgenerate

   wire [PAG_NPINS-1:0] level_rd = pin_sync & din_en;
   wire [PAG_NPINS-1:0] dir_rd = direction_q & pin_free;
   wire [PAG_NPINS-1:0] lat_rd = latch_q & pin_free;

   // Read multiplexer
   logic [PAG_DW-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      unique case (rif.addr)
         PAG_DIR_OFS: rd_mux = dir_rd;
         PAG_PIN_OFS: rd_mux = level_rd;
         PAG_LAT_OFS: rd_mux = lat_rd;
         PAG_ANA_OFS: rd_mux = analog_q;
         PAG_CMP_OFS: rd_mux = cmp_q;
         PAG_OSC_OFS: rd_mux = {5'h00, osc_q};
         PAG_STA_OFS: rd_mux = pin_oe_q;
         default: rd_mux = '0;
      endcase
   end
   assign rif.rdata = rd_mux;

   // Register next values
   assign direction_d = wr_dir ? rif.wdata : direction_q;
   assign latch_d = (wr_pin | wr_lat) ? rif.wdata : latch_q;
   assign analog_d = wr_ana ? (rif.wdata & PAG_ANA_MASK) : analog_q;
   assign cmp_d = wr_cmp ? (rif.wdata & PAG_CMP_MASK) : cmp_q;
   assign osc_d = wr_osc ? osc_decode(rif.wdata[2:0]) : osc_q;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         direction_q <= PAG_DIR_RST;
         latch_q <= PAG_LAT_RST;
         analog_q <= PAG_ANA_RST;
         cmp_q <= PAG_CMP_RST;
         osc_q <= pag_osc_e'(PAG_OSC_RST);
      end else if (ce) begin
         direction_q <= direction_d;
         latch_q <= latch_d;
         analog_q <= analog_d;
         cmp_q <= cmp_d;
         osc_q <= osc_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         div_q <= '0;
      end else if (ce) begin
         div_q <= div_q + PAG_DIV_W'(1);
      end
   end

   wire tmr_d = direction_q[PAG_TMR_PIN] ? pin_sync[PAG_TMR_PIN] : 1'b0;
   wire ss_n_d = direction_q[PAG_SS_PIN] ? pin_sync[PAG_SS_PIN] : 1'b1;

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pin_out_q <= '0;
         pin_oe_q <= '0;
         tmr_q <= 1'b0;
         ss_n_q <= 1'b1;
         cref_q <= 1'b0;
      end else if (ce) begin
         pin_out_q <= drv_val;
         pin_oe_q <= drv_en;
         tmr_q <= tmr_d;
         ss_n_q <= ss_n_d;
         cref_q <= cref_en;
      end
   end

   assign pin_out = pin_out_q;
   assign pin_oe = pin_oe_q;
   assign timer_clock_in = tmr_q;
   assign slave_select_n = ss_n_q;
   assign comparator_ref_out = cref_q;
endmodule : pag_top

//--- test/pag_top_asserts.sv
/* Port-level checker for pag_top, bound to every instance.
 * Assumes the single clk_sys domain; ce low restarts the settle count. */
`timescale 1ns/1ps
module pag_top_asserts
   import pag_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [PAG_NPINS-1:0] pin_in,
   input wire logic [PAG_NPINS-1:0] pin_out,
   input wire logic [PAG_NPINS-1:0] pin_oe,
   input wire logic timer_clock_in,
   input wire logic slave_select_n,
   input wire logic comparator_ref_out
);
   logic [2:0] rel_q;
   wire logic wr_done = avs_write && !avs_waitrequest;
   // Cycles since reset or freeze, saturating
   always_ff @(posedge clk_sys) begin
      if (!nrst || !ce) rel_q <= 3'h0;
      else if (rel_q != 3'h7) rel_q <= rel_q + 3'h1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   a_bus_one_wait: assert property (s_req |=> s_ans)
      else $error("bus answer not after one wait state");
   a_bus_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
      else $error("waitrequest low while idle");
   a_rdata_upper_zero: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_ref_kills_drive: assert property (
      comparator_ref_out && $past(comparator_ref_out) |-> !pin_oe[PAG_CREF_PIN])
      else $error("pin 2 driven with reference out");
   a_oe_after_write: assert property ($changed(pin_oe) |-> $past(wr_done, 2))
      else $error("output enable moved without write");
   a_out_after_write: assert property (
      $changed(pin_out[3:0]) |-> $past(wr_done, 2))
      else $error("low pin drive moved without write");
   a_timer_follows: assert property (
      (!pin_oe[PAG_TMR_PIN]) [*4] ##0 rel_q == 3'h7
      |-> timer_clock_in == $past(pin_in[PAG_TMR_PIN], 3))
      else $error("timer clock input not following pin 4");
   a_select_follows: assert property (
      (!pin_oe[PAG_SS_PIN]) [*4] ##0 rel_q == 3'h7
      |-> slave_select_n == $past(pin_in[PAG_SS_PIN], 3))
      else $error("slave select not following pin 5");
endmodule : pag_top_asserts
bind pag_top pag_top_asserts pag_top_asserts_i (.clk_sys, .nrst, .ce, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .timer_clock_in,
   .slave_select_n, .comparator_ref_out);

//--- test/pag_board.sv
/* Board model on the eight port pins.
 * Assumes the board drives every pin the port leaves undriven. */
`timescale 1ns/1ps
module pag_board
   import pag_pkg::*;
(
   input wire logic [PAG_NPINS-1:0] pin_out,
   input wire logic [PAG_NPINS-1:0] pin_oe,
   input wire logic [PAG_NPINS-1:0] ext_d,
   output logic [PAG_NPINS-1:0] pin_in
);
   // Driven pins show the port, others the board
   assign pin_in = (pin_out & pin_oe) | (ext_d & ~pin_oe);
endmodule : pag_board

//--- test/tb_port_a_gpio_with_analog_share.sv
/* Self-checking bench for pag_top with queued expectations.
 * Assumes pag_board and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb_port_a_gpio_with_analog_share;
   import pag_pkg::*;
   logic clk_sys, nrst, ce, avs_read, avs_write, avs_waitrequest, cmp1, cmp2;
   logic obs_en, obs_sel, tck, ssn, cref, io6, io7, ck6;
   logic [4:0] avs_address;
   logic [3:0] be;
   logic [31:0] avs_writedata, avs_readdata, obs_val, e, v, d, l, r;
   logic [31:0] rs = 32'h91FA;
   logic [7:0] pin_in, pin_out, pin_oe, ext_d;
   int err_count = 0;
   int compares = 0;
   logic [31:0] exp_q[$];
   string nm_q[$];
   string nm;
   pag_top pag_top_i (.clk_sys, .nrst, .ce, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(be), .avs_readdata, .avs_waitrequest, .pin_in,
      .pin_out, .pin_oe, .comparator_one_out(cmp1), .comparator_two_out(cmp2),
      .timer_clock_in(tck), .slave_select_n(ssn), .comparator_ref_out(cref));
   pag_board pag_board_i (.pin_out, .pin_oe, .ext_d, .pin_in);
   assign obs_val = obs_sel ? {31'h0, pin_out[6]} : {29'h0, tck, ssn, cref};
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   task automatic stop_test();
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] x);
      avs_address <= a;
      avs_writedata <= {24'h0, x};
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [7:0] x);
      bus(1'b1, a, x);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] x, input string s);
      exp_q.push_back({24'h0, x});
      nm_q.push_back(s);
      bus(1'b0, a, 8'h00);
   endtask : rd
   task automatic ob(input logic [31:0] x, input string s);
      exp_q.push_back(x);
      nm_q.push_back(s);
      obs_sel <= 1'b0;
      obs_en <= 1'b1;
      @(posedge clk_sys);
      obs_en <= 1'b0;
      @(posedge clk_sys);
   endtask : ob
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if ((avs_read && avs_waitrequest === 1'b0) || obs_en) begin
         e = exp_q.pop_front();
         nm = nm_q.pop_front();
         v = obs_en ? obs_val : avs_readdata;
         compares++;
         if (v !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, v);
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      stop_test();
   end
   initial begin
      {nrst, avs_read, avs_write, cmp1, cmp2, obs_en, obs_sel} <= '0;
      {avs_address, avs_writedata, ext_d} <= '0;
      be <= 4'hF;
      ce <= 1'b1;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      rd(PAG_DIR_OFS, PAG_DIR_RST, "dir");
      rd(PAG_LAT_OFS, PAG_LAT_RST, "lat");
      rd(PAG_ANA_OFS, PAG_ANA_RST, "ana");
      rd(PAG_OSC_OFS, 8'h04, "osc");
      rd(PAG_STA_OFS, 8'h00, "sta");
      ext_d <= 8'hFF;
      wr(5'h1C, 8'hFF);
      rd(5'h1C, 8'h00, "gap");
      rd(PAG_PIN_OFS, 8'hD0, "pin");
      ob(32'h6, "aux");
      r = rnd();
      ext_d <= r[7:0];
      wr(PAG_ANA_OFS, 8'hFF);
      rd(PAG_ANA_OFS, PAG_ANA_MASK, "ana");
      rd(PAG_PIN_OFS, r[7:0] & 8'hD0, "pin");
      wr(PAG_ANA_OFS, 8'h00);
      wr(PAG_CMP_OFS, 8'h01);
      rd(PAG_PIN_OFS, r[7:0] & 8'hF0, "pin");
      wr(PAG_CMP_OFS, 8'h08);
      rd(PAG_PIN_OFS, r[7:0] & 8'hFB, "pin");
      wr(PAG_DIR_OFS, 8'h00);
      rd(PAG_STA_OFS, 8'hFB, "sta");
      ob(32'h3, "aux");
      wr(PAG_CMP_OFS, 8'h00);
      for (int k = 0; k < 4; k++) begin
         d = rnd();
         l = rnd();
         wr(PAG_DIR_OFS, d[7:0]);
         wr(k[0] ? PAG_LAT_OFS : PAG_PIN_OFS, l[7:0]);
         rd(PAG_LAT_OFS, l[7:0], "lat");
         rd(PAG_STA_OFS, ~d[7:0], "sta");
         rd(PAG_PIN_OFS, (l[7:0] & ~d[7:0]) | (r[7:0] & d[7:0]), "pin");
      end
      be <= 4'h0;
      wr(PAG_LAT_OFS, ~l[7:0]);
      be <= 4'hF;
      rd(PAG_LAT_OFS, l[7:0], "lat");
      wr(PAG_DIR_OFS, 8'h00);
      wr(PAG_LAT_OFS, 8'h00);
      wr(PAG_CMP_OFS, 8'h06);
      for (int i = 1; i < 3; i++) begin
         {cmp2, cmp1} <= i[1:0];
         repeat (4) @(posedge clk_sys);
         rd(PAG_PIN_OFS, {2'b00, i[1:0], 4'h0}, "pin");
      end
      wr(PAG_LAT_OFS, 8'hFF);
      wr(PAG_CMP_OFS, 8'h00);
      for (int m = 0; m < 8; m++) begin
         io6 = m inside {2, 4, 6};
         ck6 = m inside {1, 3, 5};
         io7 = m inside {3, 4};
         wr(PAG_OSC_OFS, m[7:0]);
         rd(PAG_OSC_OFS, (m == 7) ? 8'h00 : m[7:0], "osc");
         wr(PAG_DIR_OFS, 8'hFF);
         rd(PAG_DIR_OFS, {io7, io6, 6'h3F}, "dir");
         wr(PAG_DIR_OFS, 8'h00);
         rd(PAG_LAT_OFS, {io7, io6, 6'h3F}, "lat");
         rd(PAG_STA_OFS, {io7, io6 | ck6, 6'h3F}, "sta");
         rd(PAG_PIN_OFS, {io7, io6, 6'h3F}, "pin");
         if (ck6) begin
            do @(posedge clk_sys); while (pin_out[6] !== 1'b0);
            do @(posedge clk_sys); while (pin_out[6] !== 1'b1);
            for (int i = 0; i < 4; i++) begin
               exp_q.push_back({31'h0, i == 0 || i == 3});
               nm_q.push_back("cycle_clock_out");
            end
            obs_sel <= 1'b1;
            obs_en <= 1'b1;
            repeat (4) @(posedge clk_sys);
            obs_en <= 1'b0;
            @(posedge clk_sys);
         end
      end
      // Clock enable low freezes the pad synchroniser and feeds
      wr(PAG_DIR_OFS, 8'hFF);
      ext_d <= 8'h00;
      repeat (4) @(posedge clk_sys);
      ob(32'h0, "aux");
      ce <= 1'b0;
      ext_d <= 8'hFF;
      repeat (4) @(posedge clk_sys);
      ob(32'h0, "frz");
      ce <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ob(32'h6, "aux");
      stop_test();
   end
endmodule : tb_port_a_gpio_with_analog_share
